//--- hdl/srm_params.svh
// constants for the speed, rectifier and alarm-level monitor
`ifndef SRM_PARAMS_SVH
`define SRM_PARAMS_SVH

// clock and time base
`define SRM_CLK_NS        40
`define SRM_TICK_NS       1000000

// data widths
`define SRM_SW            16
`define SRM_VW            18
`define SRM_ACC           48
`define SRM_SPD_W         16
`define SRM_DLY_W         16

// register indices on the plain register port
`define SRM_IDX_CTRL      8'h00
`define SRM_IDX_STAT      8'h01
`define SRM_IDX_MASK      8'h02
`define SRM_IDX_SCFG      8'h03
`define SRM_IDX_ALARM     8'h04
`define SRM_IDX_LATCH     8'h05
`define SRM_IDX_MCFG      8'h08
`define SRM_IDX_MVAL      8'h10
`define SRM_IDX_SVAL      8'h18
`define SRM_BLK_LEVEL     3'h2
`define SRM_BLK_HYST      3'h3
`define SRM_BLK_DELAY     3'h4

// field positions and reset values
`define SRM_CTRL_CLR      0
`define SRM_MCFG_MODE_LSB 0
`define SRM_MCFG_SHF_LSB  4
`define SRM_SCFG_GATE_LSB 16
`define SRM_MCFG_RST      32'h0000_00a0
`define SRM_SCFG_RST      32'h03e8_0003
`define SRM_LVL_HI_RST    18'h3ffff
`define SRM_LVL_LO_RST    18'h00000

// scale factors, unsigned Q16
`define SRM_K_SMEAN       18'h0e666
`define SRM_K_SPEAK       18'h16a0a
`define SRM_K_SP2P        18'h2d414

`endif

//--- hdl/srm_pkg.sv
// types shared by the monitor modules
package srm_pkg;

  typedef enum logic [2:0] {
    RECT_RMS, RECT_SMEAN, RECT_SPEAK, RECT_SP2P, RECT_MEAN, RECT_TPEAK, RECT_TP2P
  } rect_mode_t;

  typedef enum logic [1:0] {
    LVL_IDLE, LVL_QUAL, LVL_ALARM
  } lvl_state_t;

endpackage

//--- hdl/srm_level.sv
// one alarm level: comparison, hysteresis, qualifying delay and latch
`timescale 1ns/10ps
`default_nettype none
module srm_level #(
  parameter int VW = 18,
  parameter int DW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          isUpper,
  input  wire logic [VW-1:0] value,
  input  wire logic [VW-1:0] level,
  input  wire logic [VW-1:0] hyst,
  input  wire logic [DW-1:0] delayMs,
  input  wire logic          latchEn,
  input  wire logic          clearLatch,
  output logic               alarm,
  output logic               fired
);

  srm_pkg::lvl_state_t state_ff, nxt_state;
  logic [DW-1:0]       cnt_ff, nxt_cnt;
  logic                alarm_ff, nxt_alarm;
  logic                event_ff, nxt_event;
  logic                beyond;
  logic                released;

  // extra bit keeps level plus hysteresis from wrapping
  always_comb begin
    beyond   = isUpper ? (value > level) : (value < level);
    released = isUpper ? ({1'b0, value} + {1'b0, hyst} <= {1'b0, level})
                       : ({1'b0, value} >= {1'b0, level} + {1'b0, hyst});
  end

  // qualify, hold and release
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_event = 1'b0;
    unique case (state_ff)
      srm_pkg::LVL_IDLE: begin
        nxt_cnt = '0;
        if (beyond) begin
          nxt_state = srm_pkg::LVL_QUAL;
        end
      end
      srm_pkg::LVL_QUAL: begin
        if (!beyond) begin
          nxt_state = srm_pkg::LVL_IDLE;  // RULE_18
          nxt_cnt   = '0;                  // RULE_18
        end else if (tick) begin
          if (cnt_ff >= delayMs) begin
            nxt_state = srm_pkg::LVL_ALARM;  // RULE_13
            nxt_event = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;         // RULE_13
          end
        end
      end
      srm_pkg::LVL_ALARM: begin
        if (latchEn) begin
          if (clearLatch) begin
            nxt_state = srm_pkg::LVL_IDLE;  // RULE_16
          end
        end else if (released) begin
          nxt_state = srm_pkg::LVL_IDLE;    // RULE_17
        end
      end
    endcase
    nxt_alarm = (nxt_state == srm_pkg::LVL_ALARM);  // RULE_15
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= srm_pkg::LVL_IDLE;
      cnt_ff   <= '0;
      alarm_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      alarm_ff <= nxt_alarm;
      event_ff <= nxt_event;
    end
  end

  assign alarm = alarm_ff;
  assign fired = event_ff;

endmodule
`default_nettype wire

//--- hdl/speed_rectify_alarm_monitor.sv
// speed edge detection, rectification and alarm levels of a monitoring card
// Behaviour
// (RULE_01) speed inputs serve only for edge detection
// (RULE_02) active edge of each speed input, rising or falling, set by software
// (RULE_03) speed input takes once-per-turn pulse or multi-tooth train
// (RULE_04) falling threshold is negative peak plus two thirds of peak span
// (RULE_05) rising threshold is negative peak plus one third of peak span
// (RULE_06) rms and mean-absolute rectification over the averaging time
// (RULE_07) scaled mean is rms times 0.900
// (RULE_08) scaled peak is rms times root two, peak-to-peak twice that
// (RULE_09) true peak is peak magnitude; true p2p is positive minus negative peak
// (RULE_10) averaging time is set by software
// (RULE_11) measurement channels have upper trip, upper warning, lower warning, lower trip
// (RULE_12) speed channels have only upper and lower warning levels
// (RULE_13) alarm only after value stays beyond level longer than its delay
// (RULE_14) each level has its own hysteresis amount
// (RULE_15) alarms optionally latched, staying set after the condition ends
// (RULE_16) latched alarms clear by external reset pin or clear command
// (RULE_17) unlatched alarm drops once value is back inside by the hysteresis
// (RULE_18) value back inside before the delay restarts the delay count
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "srm_params.svh"
module speed_rectify_alarm_monitor #(
  parameter int  NM          = 4,
  parameter int  NS          = 2,
  parameter int  TICK_CYCLES = `SRM_TICK_NS / `SRM_CLK_NS,
  localparam int SW          = `SRM_SW,
  localparam int NA          = 4 * NM + 2 * NS
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWrData,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [31:0]      regRdData,
  input  wire logic [NM*SW-1:0] measSample,
  input  wire logic [NM-1:0]    measValid,
  input  wire logic [NS*SW-1:0] speedSample,
  input  wire logic [NS-1:0]    speedValid,
  input  wire logic             extLatchClr_n,
  output logic      [NS-1:0]    speedEdge,
  output logic      [NA-1:0]    alarm,
  output logic                  irq
);

  localparam int VW  = `SRM_VW;
  localparam int AW  = `SRM_ACC;
  localparam int PW  = `SRM_SPD_W;
  localparam int DW  = `SRM_DLY_W;
  localparam int TW  = $clog2(TICK_CYCLES + 1);
  localparam int THW = SW + 4;

  // integer square root, one result bit per step
  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] root;
    logic [15:0] trial;
    root = '0;
    for (int i = 15; i >= 0; i--) begin
      trial = root | (16'h0001 << i);
      if ({16'h0000, trial} * {16'h0000, trial} <= v) begin
        root = trial;
      end
    end
    return root;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick and external clear synchroniser

  logic [TW-1:0] tickCnt_ff, nxt_tickCnt;
  logic          tick_ff, nxt_tick;
  logic          syncA_ff, syncB_ff;
  logic          cmdClr_ff, nxt_cmdClr;
  logic          clearLatch;

  // one tick paces all delays and gates
  always_comb begin
    nxt_tick    = (tickCnt_ff == TW'(TICK_CYCLES - 1));
    nxt_tickCnt = nxt_tick ? '0 : tickCnt_ff + 1'b1;
    nxt_cmdClr  = regWr && (regAddr == `SRM_IDX_CTRL) && regWrData[`SRM_CTRL_CLR];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_ff <= '0;
      tick_ff    <= 1'b0;
      syncA_ff   <= 1'b1;
      syncB_ff   <= 1'b1;
      cmdClr_ff  <= 1'b0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
      tick_ff    <= nxt_tick;
      syncA_ff   <= extLatchClr_n;
      syncB_ff   <= syncA_ff;
      cmdClr_ff  <= nxt_cmdClr;
    end
  end

  // pin low holds latches clear
  assign clearLatch = cmdClr_ff | ~syncB_ff;  // RULE_16

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [31:0]   mcfg_ff [NM];
  logic [31:0]   nxt_mcfg [NM];
  logic [31:0]   scfg_ff, nxt_scfg;
  logic [NA-1:0] mask_ff, nxt_mask;
  logic [NA-1:0] latchEn_ff, nxt_latchEn;
  logic [VW-1:0] level_ff [NA];
  logic [VW-1:0] nxt_level [NA];
  logic [VW-1:0] hyst_ff [NA];
  logic [VW-1:0] nxt_hyst [NA];
  logic [DW-1:0] delay_ff [NA];
  logic [DW-1:0] nxt_delay [NA];
  logic [NA-1:0] isUpper;

  // upper levels come first in each channel's group
  always_comb begin
    for (int a = 0; a < NA; a++) begin
      isUpper[a] = (a < 4 * NM) ? ((a % 4) < 2) : (((a - 4 * NM) % 2) == 0);  // RULE_11 RULE_12
    end
  end

  // software writes
  always_comb begin
    nxt_scfg    = scfg_ff;
    nxt_mask    = mask_ff;
    nxt_latchEn = latchEn_ff;
    for (int c = 0; c < NM; c++) begin
      nxt_mcfg[c] = mcfg_ff[c];
      if (regWr && regAddr == (`SRM_IDX_MCFG + 8'(c))) begin
        nxt_mcfg[c] = regWrData;  // RULE_10
      end
    end
    for (int a = 0; a < NA; a++) begin
      nxt_level[a] = level_ff[a];
      nxt_hyst[a]  = hyst_ff[a];
      nxt_delay[a] = delay_ff[a];
      if (regWr && regAddr[4:0] == 5'(a)) begin
        if (regAddr[7:5] == `SRM_BLK_LEVEL) nxt_level[a] = regWrData[VW-1:0];  // RULE_11
        if (regAddr[7:5] == `SRM_BLK_HYST)  nxt_hyst[a]  = regWrData[VW-1:0];  // RULE_14
        if (regAddr[7:5] == `SRM_BLK_DELAY) nxt_delay[a] = regWrData[DW-1:0];  // RULE_13
      end
    end
    if (regWr && regAddr == `SRM_IDX_SCFG)  nxt_scfg    = regWrData;           // RULE_02
    if (regWr && regAddr == `SRM_IDX_MASK)  nxt_mask    = regWrData[NA-1:0];
    if (regWr && regAddr == `SRM_IDX_LATCH) nxt_latchEn = regWrData[NA-1:0];  // RULE_15
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scfg_ff    <= `SRM_SCFG_RST;
      mask_ff    <= '0;
      latchEn_ff <= '0;
      for (int c = 0; c < NM; c++) mcfg_ff[c] <= `SRM_MCFG_RST;
      for (int a = 0; a < NA; a++) begin
        level_ff[a] <= ((a < 4 * NM) ? ((a % 4) < 2) : (((a - 4 * NM) % 2) == 0))
                       ? `SRM_LVL_HI_RST : `SRM_LVL_LO_RST;
        hyst_ff[a]  <= '0;
        delay_ff[a] <= '0;
      end
    end else begin
      scfg_ff    <= nxt_scfg;
      mask_ff    <= nxt_mask;
      latchEn_ff <= nxt_latchEn;
      mcfg_ff    <= nxt_mcfg;
      level_ff   <= nxt_level;
      hyst_ff    <= nxt_hyst;
      delay_ff   <= nxt_delay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement rectifiers, one per channel

  logic [VW-1:0] measVal [NM];

  for (genvar c = 0; c < NM; c++) begin : g_meas
    logic signed [SW-1:0] smp;
    logic signed [31:0]   smpX;
    logic [SW:0]          absV;
    logic [31:0]          sq;
    logic [3:0]           shf;
    srm_pkg::rect_mode_t  mode;
    logic                 winEnd;
    logic [AW-1:0]        sqTot, absTot, meanSq;
    logic [15:0]          rms;
    logic [33:0]          pSm, pSp, pSpp;
    logic signed [SW-1:0] posN, negN;
    logic [SW:0]          absPkN;
    logic [AW-1:0]        sqAcc_ff, nxt_sqAcc, absAcc_ff, nxt_absAcc;
    logic [15:0]          cnt_ff, nxt_cnt;
    logic signed [SW-1:0] pos_ff, nxt_pos, neg_ff, nxt_neg;
    logic [SW:0]          absPk_ff, nxt_absPk;
    logic [VW-1:0]        val_ff, nxt_val;

    // window of 2**shf samples keeps the mean a plain shift
    always_comb begin
      smp     = signed'(measSample[c*SW +: SW]);
      smpX    = 32'(smp);
      absV    = smp[SW-1] ? (SW+1)'(-smpX) : {1'b0, smp};
      sq      = $unsigned(smpX * smpX);
      shf     = mcfg_ff[c][`SRM_MCFG_SHF_LSB +: 4];
      mode    = srm_pkg::rect_mode_t'(mcfg_ff[c][`SRM_MCFG_MODE_LSB +: 3]);
      winEnd  = measValid[c] && (cnt_ff >= 16'((17'h00001 << shf) - 17'h00001));
      sqTot   = sqAcc_ff + AW'(sq);
      absTot  = absAcc_ff + AW'(absV);
      meanSq  = sqTot >> shf;                                 // RULE_06
      rms     = isqrt(meanSq[31:0]);                          // RULE_06
      pSm     = 34'(rms) * 34'(`SRM_K_SMEAN);                 // RULE_07
      pSp     = 34'(rms) * 34'(`SRM_K_SPEAK);                 // RULE_08
      pSpp    = 34'(rms) * 34'(`SRM_K_SP2P);                  // RULE_08
      posN    = (smp > pos_ff) ? smp : pos_ff;
      negN    = (smp < neg_ff) ? smp : neg_ff;
      absPkN  = (absV > absPk_ff) ? absV : absPk_ff;          // RULE_09
      nxt_sqAcc  = sqAcc_ff;
      nxt_absAcc = absAcc_ff;
      nxt_cnt    = cnt_ff;
      nxt_pos    = pos_ff;
      nxt_neg    = neg_ff;
      nxt_absPk  = absPk_ff;
      nxt_val    = val_ff;
      if (winEnd) begin
        unique case (mode)
          srm_pkg::RECT_RMS:   nxt_val = VW'(rms);
          srm_pkg::RECT_SMEAN: nxt_val = pSm[33:16];
          srm_pkg::RECT_SPEAK: nxt_val = pSp[33:16];
          srm_pkg::RECT_SP2P:  nxt_val = pSpp[33:16];
          srm_pkg::RECT_MEAN:  nxt_val = VW'(absTot >> shf);   // RULE_06
          srm_pkg::RECT_TPEAK: nxt_val = VW'(absPkN);          // RULE_09
          srm_pkg::RECT_TP2P:  nxt_val = VW'(18'(posN) - 18'(negN));  // RULE_09
          default:             nxt_val = VW'(rms);
        endcase
        nxt_sqAcc  = '0;
        nxt_absAcc = '0;
        nxt_cnt    = '0;
        nxt_pos    = {1'b1, {(SW-1){1'b0}}};
        nxt_neg    = {1'b0, {(SW-1){1'b1}}};
        nxt_absPk  = '0;
      end else if (measValid[c]) begin
        nxt_sqAcc  = sqTot;
        nxt_absAcc = absTot;
        nxt_cnt    = cnt_ff + 1'b1;
        nxt_pos    = posN;
        nxt_neg    = negN;
        nxt_absPk  = absPkN;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        sqAcc_ff  <= '0;
        absAcc_ff <= '0;
        cnt_ff    <= '0;
        pos_ff    <= {1'b1, {(SW-1){1'b0}}};
        neg_ff    <= {1'b0, {(SW-1){1'b1}}};
        absPk_ff  <= '0;
        val_ff    <= '0;
      end else begin
        sqAcc_ff  <= nxt_sqAcc;
        absAcc_ff <= nxt_absAcc;
        cnt_ff    <= nxt_cnt;
        pos_ff    <= nxt_pos;
        neg_ff    <= nxt_neg;
        absPk_ff  <= nxt_absPk;
        val_ff    <= nxt_val;
      end
    end

    assign measVal[c] = val_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed inputs: thresholds, edges, edge count per gate

  logic [PW-1:0] speedVal [NS];

  for (genvar s = 0; s < NS; s++) begin : g_speed
    logic signed [SW-1:0]  ss;
    logic signed [THW-1:0] span, upThrN, loThrN, ssX;
    logic                  rise, fall, actEdge, gateEnd;
    logic [15:0]           gateMs;
    logic signed [SW-1:0]  runPos_ff, nxt_runPos, runNeg_ff, nxt_runNeg;
    logic signed [THW-1:0] upThr_ff, nxt_upThr, loThr_ff, nxt_loThr;
    logic                  hi_ff, nxt_hi, edge_ff, nxt_edge;
    logic [PW-1:0]         edgeCnt_ff, nxt_edgeCnt, spd_ff, nxt_spd;
    logic [15:0]           gate_ff, nxt_gate;

    // thresholds from previous gate's peaks
    always_comb begin
      ss      = signed'(speedSample[s*SW +: SW]);
      ssX     = THW'(ss);
      span    = THW'(runPos_ff) - THW'(runNeg_ff);
      upThrN  = THW'(runNeg_ff) + THW'((span * 2) / 3);  // RULE_04
      loThrN  = THW'(runNeg_ff) + THW'(span / 3);   // RULE_05
      gateMs  = scfg_ff[`SRM_SCFG_GATE_LSB +: 16];
      rise    = speedValid[s] && !hi_ff && (ssX > loThr_ff);  // RULE_05
      fall    = speedValid[s] && hi_ff && (ssX < upThr_ff);   // RULE_04
      // only edges count
      actEdge = scfg_ff[s] ? rise : fall;           // RULE_01 RULE_02
      gateEnd = tick_ff && (gate_ff + 16'h0001 >= gateMs);
      nxt_hi     = rise ? 1'b1 : (fall ? 1'b0 : hi_ff);
      nxt_edge   = actEdge;
      nxt_runPos = runPos_ff;
      nxt_runNeg = runNeg_ff;
      if (speedValid[s]) begin
        if (ss > runPos_ff) nxt_runPos = ss;
        if (ss < runNeg_ff) nxt_runNeg = ss;
      end
      nxt_upThr   = upThr_ff;
      nxt_loThr   = loThr_ff;
      nxt_spd     = spd_ff;
      nxt_gate    = tick_ff ? gate_ff + 16'h0001 : gate_ff;
      // one pulse per edge, whether once per turn or per tooth
      nxt_edgeCnt = edgeCnt_ff + PW'(actEdge);      // RULE_03
      if (gateEnd) begin
        nxt_spd     = edgeCnt_ff;
        nxt_edgeCnt = PW'(actEdge);
        nxt_gate    = '0;
        nxt_upThr   = upThrN;
        nxt_loThr   = loThrN;
        nxt_runPos  = {1'b1, {(SW-1){1'b0}}};
        nxt_runNeg  = {1'b0, {(SW-1){1'b1}}};
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        runPos_ff  <= {1'b1, {(SW-1){1'b0}}};
        runNeg_ff  <= {1'b0, {(SW-1){1'b1}}};
        upThr_ff   <= '0;
        loThr_ff   <= '0;
        hi_ff      <= 1'b0;
        edge_ff    <= 1'b0;
        edgeCnt_ff <= '0;
        spd_ff     <= '0;
        gate_ff    <= '0;
      end else begin
        runPos_ff  <= nxt_runPos;
        runNeg_ff  <= nxt_runNeg;
        upThr_ff   <= nxt_upThr;
        loThr_ff   <= nxt_loThr;
        hi_ff      <= nxt_hi;
        edge_ff    <= nxt_edge;
        edgeCnt_ff <= nxt_edgeCnt;
        spd_ff     <= nxt_spd;
        gate_ff    <= nxt_gate;
      end
    end

    assign speedVal[s]  = spd_ff;
    assign speedEdge[s] = edge_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm levels, one instance per level

  logic [NA-1:0] lvlEvent;

  for (genvar a = 0; a < NA; a++) begin : g_level
    logic [VW-1:0] val;
    // four levels per measurement, two per speed channel
    assign val = (a < 4 * NM) ? measVal[a / 4] : VW'(speedVal[(a - 4 * NM) / 2]);  // RULE_11 RULE_12

    srm_level #(.VW(VW), .DW(DW)) u_level (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .tick       (tick_ff),
      .isUpper    (isUpper[a]),
      .value      (val),
      .level      (level_ff[a]),
      .hyst       (hyst_ff[a]),
      .delayMs    (delay_ff[a]),
      .latchEn    (latchEn_ff[a]),
      .clearLatch (clearLatch),
      .alarm      (alarm[a]),
      .fired      (lvlEvent[a])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and register read-back

  logic [NA-1:0] stat_ff, nxt_stat;
  logic          irq_ff, nxt_irq;
  logic [31:0]   rdData_ff, nxt_rdData;

  // read clears status; a same-cycle event wins
  always_comb begin
    nxt_stat = stat_ff;
    if (regRd && regAddr == `SRM_IDX_STAT) nxt_stat = '0;
    nxt_stat = nxt_stat | lvlEvent;
    nxt_irq  = |(nxt_stat & mask_ff);
  end

  // read data one cycle after the strobe
  always_comb begin
    nxt_rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        `SRM_IDX_STAT:  nxt_rdData = 32'(stat_ff);
        `SRM_IDX_MASK:  nxt_rdData = 32'(mask_ff);
        `SRM_IDX_SCFG:  nxt_rdData = scfg_ff;
        `SRM_IDX_ALARM: nxt_rdData = 32'(alarm);
        `SRM_IDX_LATCH: nxt_rdData = 32'(latchEn_ff);
        default:        nxt_rdData = '0;
      endcase
      for (int c = 0; c < NM; c++) begin
        if (regAddr == (`SRM_IDX_MCFG + 8'(c))) nxt_rdData = mcfg_ff[c];
        if (regAddr == (`SRM_IDX_MVAL + 8'(c))) nxt_rdData = 32'(measVal[c]);
      end
      for (int s = 0; s < NS; s++) begin
        if (regAddr == (`SRM_IDX_SVAL + 8'(s))) nxt_rdData = 32'(speedVal[s]);
      end
      for (int a = 0; a < NA; a++) begin
        if (regAddr[4:0] == 5'(a) && regAddr[7:5] == `SRM_BLK_LEVEL) nxt_rdData = 32'(level_ff[a]);
        if (regAddr[4:0] == 5'(a) && regAddr[7:5] == `SRM_BLK_HYST)  nxt_rdData = 32'(hyst_ff[a]);
        if (regAddr[4:0] == 5'(a) && regAddr[7:5] == `SRM_BLK_DELAY) nxt_rdData = 32'(delay_ff[a]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff   <= '0;
      irq_ff    <= 1'b0;
      rdData_ff <= '0;
    end else begin
      stat_ff   <= nxt_stat;
      irq_ff    <= nxt_irq;
      rdData_ff <= nxt_rdData;
    end
  end

  assign irq       = irq_ff;
  assign regRdData = rdData_ff;

endmodule
`default_nettype wire

//--- bench/srm_asserts.sv
// port-level checks of the monitor
`timescale 1ns/10ps
`default_nettype none
module srm_asserts #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  input wire logic [1:0]  speedValid,
  input wire logic [1:0]  speedEdge,
  input wire logic [19:0] alarm,
  input wire logic        irq
);
  int tc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // tick phase since reset
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) tc <= 0;
    else tc <= (tc == TICK_CYCLES - 1) ? 0 : tc + 1;
  ////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(regRd) |-> regRdData == '0) else $error("read data outside slot");
  a_rdata_unmapped: assert property (regRd && regAddr == 8'h07 |=> regRdData == '0) else $error("unmapped read");
  a_level_width: assert property (regRd && regAddr == 8'h41 |=> regRdData[31:18] == '0) else $error("level width");
  a_edge_single: assert property (speedEdge[0] |=> !speedEdge[0]) else $error("edge too long");
  a_edge_cause: assert property (speedEdge != '0 |-> (speedEdge & ~$past(speedValid)) == '0)
    else $error("edge without sample");
  a_reset_quiet: assert property ($rose(rst_n) |-> alarm == '0 && !irq) else $error("outputs after reset");
  a_alarm_tick: assert property ((alarm & ~$past(alarm)) != '0 |-> tc <= 3 || tc == TICK_CYCLES - 1)
    else $error("alarm off tick");
  a_irq_clear: assert property ($fell(irq) |-> $past(regRd) || $past(regRd, 2) || $past(regRd, 3) ||
    $past(regWr) || $past(regWr, 2) || $past(regWr, 3)) else $error("irq dropped alone");
endmodule
`default_nettype wire

//--- bench/srm_source.sv
// upstream filter stand-in: square measurement samples, stepped speed wave
`timescale 1ns/10ps
`default_nettype none
module srm_source (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] amp,
  output logic      [63:0] measSample,
  output logic      [3:0]  measValid,
  output logic      [31:0] speedSample,
  output logic      [1:0]  speedValid
);
  logic [2:0]  ph;
  logic [15:0] sp;
  // speed wave
  assign sp = (ph[2:1] == 2'h0) ? 16'h0000 : (ph[2:1] == 2'h2) ? 16'h012c : 16'h0096;
  // valid every other cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ph, measSample, measValid, speedSample, speedValid} <= '0;
    end else begin
      ph          <= ph + 3'h1;
      measValid   <= {4{ph[0]}};
      speedValid  <= {2{ph[0]}};
      measSample  <= ph[0] ? {4{ph[1] ? amp : -amp}} : ~measSample;
      speedSample <= ph[0] ? {2{sp}} : ~speedSample;
    end
  end
endmodule
`default_nettype wire

//--- bench/speed_rectify_alarm_monitor_tb.sv
// self-checking bench of the monitor
`timescale 1ns/10ps
`default_nettype none
`include "srm_params.svh"
module speed_rectify_alarm_monitor_tb;
  localparam int T = 10;
  localparam int PK = 300;
  logic        sys_clk, rst_n, regWr, regRd, extLatchClr_n, irq, hiSt, synced, up;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, d;
  logic [63:0] measSample;
  logic [3:0]  measValid;
  logic [31:0] speedSample;
  logic [1:0]  speedValid, speedEdge, expEdge;
  logic [19:0] alarm;
  logic [15:0] amp;
  int          mismatches, checks_done, cyc, n;
  int          lv[6] = '{0, 1, 2, 3, 16, 17};
  speed_rectify_alarm_monitor #(.TICK_CYCLES(T)) u_speed_rectify_alarm_monitor (.sys_clk, .rst_n, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .measSample, .measValid, .speedSample, .speedValid,
    .extLatchClr_n, .speedEdge, .alarm, .irq);
  srm_source u_srm_source (.sys_clk, .rst_n, .amp, .measSample, .measValid, .speedSample, .speedValid);
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge sys_clk);
  endtask
  task wt(input int a, input logic v, output int k);
    k = 0;
    while (alarm[a] !== v && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
  endtask
  function automatic logic [31:0] rect(input int m);
    logic [63:0] a;
    a = 64'(amp);
    case (m)
      1: a = (a * `SRM_K_SMEAN) >> 16;
      2: a = (a * `SRM_K_SPEAK) >> 16;
      3: a = (a * `SRM_K_SP2P) >> 16;
      6: a = a * 2;
      default: ;
    endcase
    return a[31:0];
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // edge model and timeout
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 25000) begin
      mismatches++;
      give_verdict;
    end
    if (synced) chk(32'(speedEdge), 32'(expEdge));
    expEdge = 2'h0;
    if (speedValid[0] && cyc > 10500) begin
      if (speedSample[15:0] == 16'h0) {synced, hiSt} = 2'b10;
      else if (!hiSt && speedSample[15:0] > PK / 3) {hiSt, expEdge} = 3'b101;
      else if (hiSt && speedSample[15:0] < 2 * PK / 3) {hiSt, expEdge} = 3'b010;
    end
  end
  initial begin
    {rst_n, regWr, regRd, regAddr, regWrData, hiSt, synced, expEdge} = '0;
    {mismatches, checks_done, cyc} = '0;
    extLatchClr_n = 1'b1;
    n = $urandom(32'h8e277f1e);
    amp = 16'h0100 + 16'($urandom % 32'h6000);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    wr(8'h03, 32'h0004_0001);
    wr(8'h02, 32'h000f_ffff);
    for (int m = 0; m < 8; m++) begin
      for (int c = 0; c < 4; c++) wr(8'h08 + 8'(c), 32'h20 + 32'(m));
      repeat (30) @(posedge sys_clk);
      for (int c = 0; c < 4; c++) begin
        rd(8'h10 + 8'(c), d);
        chk(d, rect(m));
      end
    end
    repeat (T * 1000 + 200) @(posedge sys_clk);
    rd(8'h18, d);
    chk(d, 32'h5);
    rd(8'h19, d);
    chk(d, 32'h5);
    rd(8'h07, d);
    chk(d, 32'h0);
    rd(8'h01, d);
    // each level kind raises and drops
    foreach (lv[i]) begin
      up = (lv[i] < 16) ? (lv[i] % 4 < 2) : (lv[i] == 16);
      wr(8'h40 + 8'(lv[i]), up ? 32'h0 : 32'h3ffff);
      wt(lv[i], 1'b1, n);
      chk(32'(n < 3 * T + 4), 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq), 32'h1);
      rd(8'h01, d);
      chk(d, 32'h1 << lv[i]);
      @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      wr(8'h40 + 8'(lv[i]), up ? 32'h3ffff : 32'h0);
      wt(lv[i], 1'b0, n);
      chk(32'(n < 3 * T + 4), 32'h1);
    end
    wr(8'h61, 32'h4);
    wr(8'h41, 32'(amp) - 32'h1);
    wt(1, 1'b1, n);
    wr(8'h41, 32'(amp) + 32'h3);
    repeat (3 * T) @(posedge sys_clk);
    chk(32'(alarm[1]), 32'h1);
    rd(8'h41, d);
    chk(d, 32'(amp) + 32'h3);
    wr(8'h41, 32'(amp) + 32'h4);
    wt(1, 1'b0, n);
    chk(32'(n < 3 * T), 32'h1);
    wr(8'h05, 32'h2);
    wr(8'h81, 32'h3);
    wr(8'h41, 32'(amp) - 32'h1);
    wt(1, 1'b1, n);
    chk(32'(n >= 3 * T && n <= 6 * T), 32'h1);
    wr(8'h41, 32'h3ffff);
    repeat (6 * T) @(posedge sys_clk);
    chk(32'(alarm[1]), 32'h1);
    wr(8'h00, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk(32'(alarm[1]), 32'h0);
    wr(8'h41, 32'(amp) - 32'h1);
    wt(1, 1'b1, n);
    wr(8'h41, 32'h3ffff);
    extLatchClr_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    extLatchClr_n <= 1'b1;
    @(posedge sys_clk);
    chk(32'(alarm[1]), 32'h0);
    give_verdict;
  end
endmodule
bind speed_rectify_alarm_monitor srm_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_srm_asserts (.sys_clk, .rst_n,
  .regAddr, .regWr, .regRd, .regRdData, .speedValid, .speedEdge, .alarm, .irq);
`default_nettype wire
